// ==== logic/wrs_reset_sequencer.sv ====
// Reset sequencer with watchdog, illegal opcode and external reset sources.
// Assumes opcode validity flags come from the core's decoder, same clock.
// The reset pin is asynchronous and is caught without a clock edge.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Reset from external pin, watchdog expiry, or illegal opcode.
// - Core starts from fixed vector address at top of memory.
// - Phases: source-dependent active, 512-cycle delay, vector fetch.
// - Vector fetch phase lasts exactly two cycles.
// - External pin detection is asynchronous, works with clocks stopped.
// - Watchdog expiry holds internal reset at least a minimum time.
// - Code matching no opcode and no prebyte triggers reset.
// - Valid prebyte with valid opcode never triggers illegal reset.
// - Count decrements every 131072 cycles, 64 programmable steps.
// - Active watchdog resets when count rolls from 40h to 3Fh.
// - Downcounter keeps running while watchdog reset is disabled.
// - Activation set with msb clear gives immediate software reset.
// - Software option: disabled after reset, only reset disables it.
// - Hardware option: always active, activation bit ignored.
// - In wait the watchdog keeps decrementing.
// - Halt entry decrements once, then stops without resets.
// - Interrupt wake from halt resumes counting after 512 cycles.
// - Reset ending halt returns watchdog to disabled state.
// - Control resets to 7Fh; flag set by software, cleared by reset.
module wrs_reset_sequencer #(
    parameter int TICK_CYCLES = wrs_pkg::WDG_TICK_CYCLES,
    parameter int DELAY_CYCLES = wrs_pkg::RST_DELAY_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ext_reset_n,
    input wire logic i_hw_option,
    input wire logic i_fetch_strobe,
    input wire logic i_opcode_valid,
    input wire logic i_prebyte_valid,
    input wire logic i_wdg_wr,
    input wire logic [7:0] i_wdg_wr_data,
    input wire logic i_halt,
    input wire logic i_wake_irq,
    output logic o_core_reset,
    output logic o_vector_fetch,
    output logic [15:0] o_vector_addr,
    output logic [7:0] o_wdg_ctrl,
    output logic [1:0] o_reset_cause
);
    initial begin
        if (DELAY_CYCLES < 1 || DELAY_CYCLES >= 2 ** wrs_pkg::PHASE_CNT_W) begin
            $error("DELAY_CYCLES out of range");
        end
    end

    // ****************************************
    // External pin capture
    // ****************************************
    // Latched asynchronously so a low pulse is seen even with clocks off
    logic ext_hit_q;
    logic ext_clr_q;
    always_ff @(posedge i_ref_clk or negedge i_ext_reset_n) begin
        if (!i_ext_reset_n) begin
            ext_hit_q <= 1'b1;
        end else if (ext_clr_q || i_reset) begin
            // Power-on reset also empties the latch, so it never starts unknown
            ext_hit_q <= 1'b0;
        end
    end
    logic ext_s1_q, ext_s2_q;
    always_ff @(posedge i_ref_clk) begin
        ext_s1_q <= ext_hit_q;
        ext_s2_q <= ext_s1_q;
    end

    // ****************************************
    // Watchdog unit
    // ****************************************
    logic wdg_expire;
    logic [7:0] wdg_ctrl;
    logic seq_reset_q, seq_reset_d;
    wrs_watchdog_unit #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wdg (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_clear(seq_reset_q),
        .i_hw_option(i_hw_option),
        .i_wr(i_wdg_wr && !seq_reset_q),
        .i_wr_data(i_wdg_wr_data),
        .i_halt(i_halt),
        .i_wake_irq(i_wake_irq),
        .o_ctrl(wdg_ctrl),
        .o_expire(wdg_expire)
    );

    // Illegal only if neither an opcode nor a prebyte matched
    logic illegal;
    assign illegal = i_fetch_strobe && !i_opcode_valid && !i_prebyte_valid;

    // ****************************************
    // Phase sequencer
    // ****************************************
    wrs_pkg::wrs_phase_e phase_q, phase_d;
    logic [wrs_pkg::PHASE_CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] cause_q, cause_d;
    logic ext_clr_d;
    logic fetch_q, fetch_d;
    logic [15:0] vaddr_q, vaddr_d;

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        cause_d = cause_q;
        ext_clr_d = 1'b0;
        seq_reset_d = seq_reset_q;
        fetch_d = 1'b0;
        vaddr_d = vaddr_q;
        case (phase_q)
            wrs_pkg::WRS_ACTIVE: begin
                seq_reset_d = 1'b1;
                if (ext_s2_q) begin
                    // Active phase lasts while the pin is held low; the
                    // latch ignores the clear while the pin still holds it
                    ext_clr_d = 1'b1;
                    cnt_d = '0;
                end else if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    phase_d = wrs_pkg::WRS_DELAY;
                    cnt_d = wrs_pkg::PHASE_CNT_W'(DELAY_CYCLES - 1);
                end
            end
            wrs_pkg::WRS_DELAY: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    phase_d = wrs_pkg::WRS_FETCH;
                    seq_reset_d = 1'b0;
                    fetch_d = 1'b1;
                    vaddr_d = wrs_pkg::RESET_VECTOR_ADDR;
                    cnt_d = wrs_pkg::PHASE_CNT_W'(
                        wrs_pkg::VECTOR_FETCH_CYCLES - 1);
                end
            end
            wrs_pkg::WRS_FETCH: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                    fetch_d = 1'b1;
                    vaddr_d = wrs_pkg::RESET_VECTOR_ADDR + 16'h0001;
                end else begin
                    phase_d = wrs_pkg::WRS_RUN;
                end
            end
            wrs_pkg::WRS_RUN: begin
                seq_reset_d = 1'b0;
            end
            default: begin
                phase_d = wrs_pkg::WRS_ACTIVE;
            end
        endcase
        // The pin restarts the sequence from any phase and has priority; the watchdog only once core reset is low, an illegal opcode only in RUN
        if (ext_s2_q && phase_q != wrs_pkg::WRS_ACTIVE) begin
            phase_d = wrs_pkg::WRS_ACTIVE;
            seq_reset_d = 1'b1;
            cause_d = 2'b01;
            cnt_d = '0;
            fetch_d = 1'b0;
        end else if ((wdg_expire || (illegal && phase_q == wrs_pkg::WRS_RUN))
                     && !seq_reset_q) begin
            phase_d = wrs_pkg::WRS_ACTIVE;
            seq_reset_d = 1'b1;
            cause_d = wdg_expire ? 2'b10 : 2'b11;
            cnt_d = wrs_pkg::PHASE_CNT_W'(wrs_pkg::WDG_RST_MIN_CYCLES);
            fetch_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            phase_q <= wrs_pkg::WRS_ACTIVE;
            cnt_q <= '0;
            cause_q <= 2'b00;
            ext_clr_q <= 1'b0;
            seq_reset_q <= 1'b1;
            fetch_q <= 1'b0;
            vaddr_q <= 16'h0000;
            o_wdg_ctrl <= wrs_pkg::WDG_CTRL_RESET;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            cause_q <= cause_d;
            ext_clr_q <= ext_clr_d;
            seq_reset_q <= seq_reset_d;
            fetch_q <= fetch_d;
            vaddr_q <= vaddr_d;
            o_wdg_ctrl <= wdg_ctrl;
        end
    end

    assign o_core_reset = seq_reset_q;
    assign o_vector_fetch = fetch_q;
    assign o_vector_addr = vaddr_q;
    assign o_reset_cause = cause_q;

    fetch_two_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(fetch_q) |-> fetch_q [*2] ##1 !fetch_q)
        else $error("vector fetch not two cycles");
    fetch_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(fetch_q) |-> vaddr_q == 16'hfffe ##1 vaddr_q == 16'hffff)
        else $error("wrong vector address");
    release_delay_a: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        phase_q == wrs_pkg::WRS_ACTIVE ##1 phase_q == wrs_pkg::WRS_DELAY
        |-> o_core_reset)
        else $error("core released before delay");
    delay_len_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(phase_q == wrs_pkg::WRS_DELAY) && !ext_s2_q && !wdg_expire
        |-> cnt_q == wrs_pkg::PHASE_CNT_W'(DELAY_CYCLES - 1))
        else $error("delay phase length wrong");
    illegal_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        illegal && phase_q == wrs_pkg::WRS_RUN |=> o_core_reset)
        else $error("illegal opcode did not reset");
    legal_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        phase_q == wrs_pkg::WRS_RUN && !ext_s2_q && !wdg_expire
        && !(i_fetch_strobe && !i_opcode_valid && !i_prebyte_valid)
        |=> !o_core_reset)
        else $error("legal code caused reset");
    wdg_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wdg_expire && !seq_reset_q |=> o_core_reset [*3])
        else $error("watchdog reset too short");
    ext_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ext_s2_q |=> phase_q == wrs_pkg::WRS_ACTIVE && o_core_reset)
        else $error("external reset not taken");
endmodule
`default_nettype wire

// ==== common/wrs_pkg.sv ====
// Constants shared by the reset sequencer and the watchdog unit.
// Assumes a single 200 MHz CPU clock for every count below.
package wrs_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_DELAY_CYCLES = 512;
    localparam int VECTOR_FETCH_CYCLES = 2;
    localparam int WAKE_DELAY_CYCLES = 512;
    localparam int WDG_TICK_CYCLES = 131072;
    // Minimum internal reset after a watchdog event, in ns
    localparam int WDG_RST_MIN_NS = 100;
    localparam int WDG_RST_MIN_CYCLES =
        (WDG_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] WDG_CTRL_RESET = 8'h7f;
    localparam int WDG_ACT_BIT = 7;
    localparam int WDG_MSB_BIT = 6;
    localparam logic [6:0] WDG_EXPIRE_FROM = 7'h40;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
    localparam int PHASE_CNT_W = 12;
    typedef enum logic [1:0] {
        WRS_ACTIVE = 2'b00,
        WRS_DELAY = 2'b01,
        WRS_FETCH = 2'b10,
        WRS_RUN = 2'b11
    } wrs_phase_e;
endpackage

// ==== logic/wrs_watchdog_unit.sv ====
// Watchdog unit: free-running 7-bit downcounter with activation flag.
// Assumes the caller resets it through i_clear when a reset sequence runs.
`timescale 1ns/1ps
`default_nettype none
module wrs_watchdog_unit #(
    parameter int TICK_CYCLES = wrs_pkg::WDG_TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic i_hw_option,
    input wire logic i_wr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_halt,
    input wire logic i_wake_irq,
    output logic [7:0] o_ctrl,
    output logic o_expire
);
    initial begin
        if (TICK_CYCLES < 2) begin
            $error("TICK_CYCLES too small");
        end
    end
    localparam int PW = $clog2(TICK_CYCLES);
    logic [PW-1:0] pre_q, pre_d;
    logic act_q, act_d;
    logic [6:0] cnt_q, cnt_d;
    logic halted_q, halted_d;
    logic [9:0] wake_q, wake_d;
    logic exp_q, exp_d;
    logic tick;
    logic halt_dec_q, halt_dec_d;

    always_comb begin
        pre_d = pre_q;
        act_d = act_q;
        cnt_d = cnt_q;
        halted_d = halted_q;
        wake_d = wake_q;
        halt_dec_d = 1'b0;
        exp_d = 1'b0;
        tick = 1'b0;
        if (pre_q == PW'(TICK_CYCLES - 1)) begin
            pre_d = '0;
            tick = 1'b1;
        end else begin
            pre_d = pre_q + 1'b1;
        end
        // On halt entry decrement once, then freeze
        if (i_halt && !halted_q && wake_q == '0) begin
            halted_d = 1'b1;
            halt_dec_d = 1'b1;
        end
        if (halted_q && i_wake_irq) begin
            halted_d = 1'b0;
            wake_d = 10'(wrs_pkg::WAKE_DELAY_CYCLES);
        end else if (wake_q != '0) begin
            wake_d = wake_q - 1'b1;
        end
        if (i_wr) begin
            cnt_d = i_wr_data[6:0];
            act_d = act_q | i_wr_data[wrs_pkg::WDG_ACT_BIT];
            // Set flag with msb clear is an immediate reset
            if ((i_wr_data[wrs_pkg::WDG_ACT_BIT] || act_q || i_hw_option)
                && !i_wr_data[wrs_pkg::WDG_MSB_BIT]) begin
                exp_d = 1'b1;
            end
        end else if (halt_dec_q || (tick && !halted_q && wake_q == '0)) begin
            // Counts also in wait and while disabled
            cnt_d = cnt_q - 1'b1;
            // Hardware option forces activation
            if ((act_q || i_hw_option) && !halted_q
                && cnt_q == wrs_pkg::WDG_EXPIRE_FROM) begin
                exp_d = 1'b1;
            end
        end
        if (i_clear) begin
            // Reset also ends halt and disables watchdog
            act_d = 1'b0;
            cnt_d = wrs_pkg::WDG_CTRL_RESET[6:0];
            halted_d = 1'b0;
            wake_d = '0;
            exp_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pre_q <= '0;
            act_q <= 1'b0;
            cnt_q <= wrs_pkg::WDG_CTRL_RESET[6:0];
            halted_q <= 1'b0;
            wake_q <= '0;
            exp_q <= 1'b0;
            halt_dec_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            act_q <= act_d;
            cnt_q <= cnt_d;
            halted_q <= halted_d;
            wake_q <= wake_d;
            exp_q <= exp_d;
            halt_dec_q <= halt_dec_d;
        end
    end

    assign o_ctrl = {act_q, cnt_q};
    assign o_expire = exp_q;

    act_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        act_q && !i_clear |=> act_q)
        else $error("activation flag cleared without reset");
    halt_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        halted_q && !i_wr |-> !exp_d)
        else $error("watchdog expiry while halted");
endmodule
`default_nettype wire

// ==== test/wrs_host_model.sv ====
// Model of the application software and the reset circuitry on the pin.
// Assumes the bench calls its tasks one at a time, just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module wrs_host_model (
    input wire logic i_ref_clk,
    output logic o_ext_reset_n,
    output logic o_wdg_wr,
    output logic [7:0] o_wdg_wr_data
);
    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        o_ext_reset_n = 1'b1;
        o_wdg_wr = 1'b0;
        o_wdg_wr_data = 8'h00;
    end

    // ****************************************
    // Pin and write tasks
    // ****************************************
    // Pull-up brings the pin back high on release
    task automatic pin_reset(input int n);
        @(posedge i_ref_clk);
        #1 o_ext_reset_n = 1'b0;
        repeat (n) @(posedge i_ref_clk);
        #1 o_ext_reset_n = 1'b1;
    endtask

    // FFh..C0h refreshes, 80h..BFh forces a reset
    task automatic write_ctrl(input logic [7:0] v);
        @(posedge i_ref_clk);
        #1 o_wdg_wr = 1'b1;
        o_wdg_wr_data = v;
        @(posedge i_ref_clk);
        #1 o_wdg_wr = 1'b0;
        // Data is not held once the write is taken
        o_wdg_wr_data = ~v;
    endtask
endmodule
`default_nettype wire

// ==== test/wrs_reset_sequencer_tb.sv ====
// Self-checking bench for the reset sequencer and its watchdog.
// Assumes shortened tick and delay counts set through the parameters.
`timescale 1ns/1ps
`default_nettype none
module wrs_reset_sequencer_tb;
    localparam int TICK = 16;
    localparam int DLY = 8;
    // Small slack for where the bench sees the reset rise
    localparam int MINW = wrs_pkg::WDG_RST_MIN_CYCLES + DLY - 2;
    logic i_ref_clk = 1'b0;
    logic i_reset, i_hw_option, i_fetch_strobe, i_opcode_valid;
    logic i_prebyte_valid, i_halt, i_wake_irq;
    logic i_ext_reset_n, i_wdg_wr;
    logic [7:0] i_wdg_wr_data, o_wdg_ctrl;
    logic o_core_reset, o_vector_fetch;
    logic [15:0] o_vector_addr;
    logic [1:0] o_reset_cause;
    logic [6:0] cnt;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int len;

    always #2.5 i_ref_clk = ~i_ref_clk;

    wrs_host_model host (
        .i_ref_clk(i_ref_clk),
        .o_ext_reset_n(i_ext_reset_n),
        .o_wdg_wr(i_wdg_wr),
        .o_wdg_wr_data(i_wdg_wr_data)
    );

    wrs_reset_sequencer #(.TICK_CYCLES(TICK), .DELAY_CYCLES(DLY)) dut (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_ext_reset_n(i_ext_reset_n),
        .i_hw_option(i_hw_option),
        .i_fetch_strobe(i_fetch_strobe),
        .i_opcode_valid(i_opcode_valid),
        .i_prebyte_valid(i_prebyte_valid),
        .i_wdg_wr(i_wdg_wr),
        .i_wdg_wr_data(i_wdg_wr_data),
        .i_halt(i_halt),
        .i_wake_irq(i_wake_irq),
        .o_core_reset(o_core_reset),
        .o_vector_fetch(o_vector_fetch),
        .o_vector_addr(o_vector_addr),
        .o_wdg_ctrl(o_wdg_ctrl),
        .o_reset_cause(o_reset_cause)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wait_rst(input int bound);
        int n;
        n = 0;
        while (o_core_reset !== 1'b1 && n < bound) begin
            step(1);
            n++;
        end
        check(n < bound, 1'b1);
    endtask

    // Waits out the delay, then checks the two fetch cycles
    task automatic boot(input logic [1:0] cause, input int min_c);
        int n;
        n = 0;
        check(o_reset_cause, cause);
        while (o_vector_fetch !== 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        check(n >= min_c && n < min_c + 40, 1'b1);
        check(o_wdg_ctrl, 8'h7f);
        check(o_core_reset, 1'b0);
        check(o_vector_addr, 16'hfffe);
        step(1);
        check({o_vector_fetch, o_vector_addr}, 17'h1ffff);
        step(1);
        check(o_vector_fetch, 1'b0);
    endtask

    task automatic do_reset();
        i_reset = 1'b1;
        step(16);
        check(o_core_reset, 1'b1);
        check(o_wdg_ctrl, 8'h7f);
        i_reset = 1'b0;
        boot(2'b00, DLY);
    endtask

    task automatic tick_len(output int n);
        logic [6:0] c;
        n = 0;
        c = o_wdg_ctrl[6:0];
        while (o_wdg_ctrl[6:0] === c && n < 200) begin
            step(1);
            n++;
        end
        c = o_wdg_ctrl[6:0];
        n = 0;
        while (o_wdg_ctrl[6:0] === c && n < 200) begin
            step(1);
            n++;
        end
        check(o_wdg_ctrl[6:0], c - 7'h01);
    endtask

    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        i_reset = 1'b1;
        i_hw_option = 1'b0;
        i_fetch_strobe = 1'b0;
        i_opcode_valid = 1'b0;
        i_prebyte_valid = 1'b0;
        i_halt = 1'b0;
        i_wake_irq = 1'b0;
        do_reset();
        tick_len(len);
        check(len, TICK);
        len = 0;
        while (o_wdg_ctrl[6:0] !== 7'h3f && len < 1200) begin
            step(1);
            len++;
        end
        step(3);
        check({o_core_reset, o_wdg_ctrl[7]}, 2'b00);
        host.write_ctrl(8'hc1);
        step(1);
        check(o_wdg_ctrl[7], 1'b1);
        wait_rst(3 * TICK + 5);
        boot(2'b10, MINW);
        check(o_wdg_ctrl[7], 1'b0);
        host.write_ctrl(8'h80);
        wait_rst(3);
        boot(2'b10, MINW);
        host.write_ctrl(8'hff);
        host.write_ctrl(8'h7f);
        step(2);
        check(o_wdg_ctrl[7], 1'b1);
        for (int k = 3; k >= 0; k--) begin
            i_fetch_strobe = 1'b1;
            i_opcode_valid = k[0];
            i_prebyte_valid = k[1];
            step(1);
            i_fetch_strobe = 1'b0;
            step(3);
            check(o_core_reset, k == 0);
        end
        boot(2'b11, MINW);
        // Count just above the expiry point, stopped by halt
        host.write_ctrl(8'hc2);
        i_halt = 1'b1;
        step(2 * TICK);
        cnt = o_wdg_ctrl[6:0];
        step(4 * TICK);
        check({o_core_reset, o_wdg_ctrl[6:0]}, {1'b0, cnt});
        i_wake_irq = 1'b1;
        step(1);
        i_wake_irq = 1'b0;
        i_halt = 1'b0;
        step(400);
        check({o_core_reset, o_wdg_ctrl[6:0]}, {1'b0, cnt});
        wait_rst(200);
        boot(2'b10, MINW);
        host.write_ctrl(8'hff);
        i_halt = 1'b1;
        step(4);
        host.pin_reset(5);
        check(o_core_reset, 1'b1);
        i_halt = 1'b0;
        boot(2'b01, DLY);
        check(o_wdg_ctrl[7], 1'b0);
        i_hw_option = 1'b1;
        do_reset();
        wait_rst(64 * TICK + 80);
        boot(2'b10, MINW);
        end_of_test();
    end
endmodule
`default_nettype wire
